// >>> seq_pkg.sv
// constants, state codes and timing counts of the regulator mode sequencer
package seq_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 100;
   localparam int CLK_HZ          = 10_000_000;
   localparam int RESET_DELAY_MS  = 100;
   localparam int WAKE_PULSE_US   = 60;
   localparam int RESET_FILTER_NS = 7500;
   localparam int RESET_DELAY_CYC = RESET_DELAY_MS * (CLK_HZ / 1000);
   localparam int WAKE_PULSE_CYC  = (WAKE_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_FILTER_CYC = (RESET_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W           = 20;
   typedef logic [CNT_W-1:0] count_t;
   localparam count_t CNT_ZERO    = 20'h00000;
   localparam count_t CNT_ONE     = 20'h00001;

   // ---------------------------------------------------------------
   // sampled input vector layout
   // ---------------------------------------------------------------
   localparam int FLAG_W          = 9;
   localparam int F_MODE          = 0;
   localparam int F_BUS           = 1;
   localparam int F_TX            = 2;
   localparam int F_SUP_LOW       = 3;
   localparam int F_SUP_OK        = 4;
   localparam int F_OUT_MRES      = 5;
   localparam int F_OUT_RES       = 6;
   localparam int F_OVER_TEMP     = 7;
   localparam int F_RECOVERED     = 8;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 9'h000;

   // ---------------------------------------------------------------
   // operating states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_POR    = 3'h0,
      ST_INI    = 3'h1,
      ST_NORMAL = 3'h2,
      ST_SLEEP  = 3'h3,
      ST_TSD    = 3'h4
   } op_state_e;
endpackage

// >>> timer_if.sv
// control and status of one delay counter
`timescale 1ns/1ps
interface timer_if;
   logic clear;
   logic done;
   modport owner   (output clear, input done);
   modport counter (input clear, output done);
endinterface

// >>> delay_timer.sv
// saturating cycle counter that flags when its limit is reached
`timescale 1ns/1ps
module delay_timer #(
   parameter seq_pkg::count_t LIMIT = seq_pkg::CNT_ONE
) (
   input wire logic clk,
   input wire logic rst,
   timer_if.counter tmr
);
   seq_pkg::count_t count_reg;
   seq_pkg::count_t count_next;

   always_comb begin
      count_next = count_reg;
      if (tmr.clear) begin
         count_next = seq_pkg::CNT_ZERO;
      end else if (count_reg != LIMIT) begin
         count_next = count_reg + seq_pkg::CNT_ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_reg <= seq_pkg::CNT_ZERO;
      end else begin
         count_reg <= count_next;
      end
   end

   assign tmr.done = (count_reg == LIMIT) && !tmr.clear;
endmodule

// >>> regulator_mode_sequencer.sv
// mode and power sequencing of the regulator and bus transceiver
`timescale 1ns/1ps
// What this block does
// - two stable modes and three transient states, transients from analogue events and from wakes in sleep
// - normal mode entered on power-up, local wake or qualified bus wake
// - mode pin falling edge in normal enters sleep, regulator off, bus recessive
// - sleep entry forces transmitter recessive immediately, never waits
// - leaving power-on reset after sleep passes initial hold into normal
// - initial hold kept while output below reset threshold, reset output low
// - over-temperature enters shutdown, transceiver off, all wakes ignored
// - recovery temperature leaves shutdown back to prior sleep, otherwise to initial hold and then normal
// - power-up goes through reset and hold into normal, ignoring mode pin
// - slow supply ramp starts regulator once supply passes release level
// - regulator starts after reset, bus enabled once output passes master threshold
// - output above reset threshold starts 100 ms delay before reset output rises
// - sleep wake re-initialises output domain in the power-up order
// - in sleep any bus level held 60 us after a bus edge turns regulator on
// - after bus wake, sleep needs mode pin high then low
// - supply under assert level in hold, sleep or shutdown enters power-on reset until release level
// - undervoltage in sleep leaves sleep, recovery continues into normal
// - initialisation on supply switch-on and on a mode pin rising edge in sleep
// - in normal mode low supply leaves regulator enabled
// - output dip below reset threshold drops reset output only after filter
// - transmit forced recessive in sleep, shutdown or master reset
module regulator_mode_sequencer #(
   parameter seq_pkg::count_t RESET_DELAY  = seq_pkg::count_t'(seq_pkg::RESET_DELAY_CYC),
   parameter seq_pkg::count_t WAKE_PULSE   = seq_pkg::count_t'(seq_pkg::WAKE_PULSE_CYC),
   parameter seq_pkg::count_t RESET_FILTER = seq_pkg::count_t'(seq_pkg::RESET_FILTER_CYC)
) (
   input  wire logic CLOCK,
   input  wire logic RST,
   input  wire logic MODE_PIN,
   input  wire logic BUS_LEVEL,
   input  wire logic TX_DATA,
   input  wire logic SUPPLY_BELOW_ASSERT,
   input  wire logic SUPPLY_ABOVE_RELEASE,
   input  wire logic OUTPUT_ABOVE_MASTER_RESET,
   input  wire logic OUTPUT_ABOVE_RESET,
   input  wire logic OVER_TEMPERATURE,
   input  wire logic BELOW_RECOVERY,
   output logic      REGULATOR_ENABLE,
   output logic      TRANSCEIVER_ENABLE,
   output logic      BUS_DOMINANT,
   output logic      RESET_OUT_N
);
   // ---------------------------------------------------------------
   // input sampling
   // ---------------------------------------------------------------
   logic [seq_pkg::FLAG_W-1:0] flags_reg;
   logic [seq_pkg::FLAG_W-1:0] flags_next;

   always_comb begin
      flags_next = {BELOW_RECOVERY, OVER_TEMPERATURE, OUTPUT_ABOVE_RESET,
                    OUTPUT_ABOVE_MASTER_RESET, SUPPLY_ABOVE_RELEASE,
                    SUPPLY_BELOW_ASSERT, TX_DATA, BUS_LEVEL, MODE_PIN};
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         flags_reg <= seq_pkg::FLAGS_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   logic mode_s;
   logic bus_s;
   logic tx_s;
   logic sup_low_s;
   logic sup_ok_s;
   logic out_mres_s;
   logic out_res_s;
   logic hot_s;
   logic cool_s;

   assign mode_s     = flags_reg[seq_pkg::F_MODE];
   assign bus_s      = flags_reg[seq_pkg::F_BUS];
   assign tx_s       = flags_reg[seq_pkg::F_TX];
   assign sup_low_s  = flags_reg[seq_pkg::F_SUP_LOW];
   assign sup_ok_s   = flags_reg[seq_pkg::F_SUP_OK];
   assign out_mres_s = flags_reg[seq_pkg::F_OUT_MRES];
   assign out_res_s  = flags_reg[seq_pkg::F_OUT_RES];
   assign hot_s      = flags_reg[seq_pkg::F_OVER_TEMP];
   assign cool_s     = flags_reg[seq_pkg::F_RECOVERED];

   // ---------------------------------------------------------------
   // delay counters
   // ---------------------------------------------------------------
   timer_if delay_t ();
   timer_if wake_t ();
   timer_if filter_t ();

   delay_timer #(.LIMIT(RESET_DELAY)) u_delay (
      .clk (CLOCK),
      .rst (RST),
      .tmr (delay_t)
   );

   delay_timer #(.LIMIT(WAKE_PULSE)) u_wake (
      .clk (CLOCK),
      .rst (RST),
      .tmr (wake_t)
   );

   delay_timer #(.LIMIT(RESET_FILTER)) u_filter (
      .clk (CLOCK),
      .rst (RST),
      .tmr (filter_t)
   );

   // ---------------------------------------------------------------
   // state decoding
   // ---------------------------------------------------------------
   // regulator runs in hold and normal
   function automatic logic powered(input seq_pkg::op_state_e s);
      return (s == seq_pkg::ST_INI) || (s == seq_pkg::ST_NORMAL);
   endfunction

   // bus interface runs in normal, in hold only above master reset
   function automatic logic bus_allowed(input seq_pkg::op_state_e s, input logic above_mres);
      return (s == seq_pkg::ST_NORMAL) || ((s == seq_pkg::ST_INI) && above_mres);
   endfunction

   function automatic logic asleep(input seq_pkg::op_state_e s);
      return s == seq_pkg::ST_SLEEP;
   endfunction

   // ---------------------------------------------------------------
   // state and history
   // ---------------------------------------------------------------
   seq_pkg::op_state_e state_reg;
   seq_pkg::op_state_e state_next;
   logic               mode_prev_reg;
   logic               mode_prev_next;
   logic               bus_prev_reg;
   logic               bus_prev_next;
   logic               was_sleep_reg;
   logic               was_sleep_next;
   logic               armed_reg;
   logic               armed_next;
   logic               mode_rise;
   logic               mode_fall;

   assign mode_rise = mode_s && !mode_prev_reg;
   assign mode_fall = !mode_s && mode_prev_reg;

   // reset delay runs only in hold with output above reset threshold
   assign delay_t.clear  = !((state_reg == seq_pkg::ST_INI) && out_res_s);
   // dip filter runs while output below reset threshold in normal
   assign filter_t.clear = !((state_reg == seq_pkg::ST_NORMAL) && !out_res_s);

   always_comb begin
      state_next     = state_reg;
      was_sleep_next = was_sleep_reg;
      armed_next     = armed_reg;
      mode_prev_next = mode_s;
      bus_prev_next  = bus_s;
      case (state_reg)
         seq_pkg::ST_POR: begin
            // mode pin is ignored here and in hold
            if (sup_ok_s && !sup_low_s) begin
               state_next = seq_pkg::ST_INI;
            end
         end
         seq_pkg::ST_INI: begin
            if (sup_low_s) begin
               state_next = seq_pkg::ST_POR;
            end else if (hot_s) begin
               state_next     = seq_pkg::ST_TSD;
               was_sleep_next = 1'b0;
            end else if (delay_t.done) begin
               state_next = seq_pkg::ST_NORMAL;
               armed_next = mode_s;
            end
         end
         seq_pkg::ST_NORMAL: begin
            if (mode_s) begin
               armed_next = 1'b1;
            end
            // undervoltage deliberately ignored here
            if (hot_s) begin
               state_next     = seq_pkg::ST_TSD;
               was_sleep_next = 1'b0;
            end else if (mode_fall && armed_reg) begin
               state_next = seq_pkg::ST_SLEEP;
            end else if (filter_t.done) begin
               state_next = seq_pkg::ST_INI;
            end
         end
         seq_pkg::ST_SLEEP: begin
            if (sup_low_s) begin
               state_next = seq_pkg::ST_POR;
            end else if (hot_s) begin
               state_next     = seq_pkg::ST_TSD;
               was_sleep_next = 1'b1;
            end else if (mode_rise) begin
               state_next = seq_pkg::ST_INI;
            end else if (wake_t.done) begin
               state_next = seq_pkg::ST_INI;
               armed_next = 1'b0;
            end
         end
         seq_pkg::ST_TSD: begin
            // wakes ignored until cooled
            if (sup_low_s) begin
               state_next = seq_pkg::ST_POR;
            end else if (cool_s) begin
               state_next = was_sleep_reg ? seq_pkg::ST_SLEEP : seq_pkg::ST_INI;
            end
         end
         default: begin
            state_next = seq_pkg::ST_POR;
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_reg     <= seq_pkg::ST_POR;
         was_sleep_reg <= 1'b0;
         armed_reg     <= 1'b0;
         mode_prev_reg <= 1'b0;
         bus_prev_reg  <= 1'b0;
      end else begin
         state_reg     <= state_next;
         was_sleep_reg <= was_sleep_next;
         armed_reg     <= armed_next;
         mode_prev_reg <= mode_prev_next;
         bus_prev_reg  <= bus_prev_next;
      end
   end

   // ---------------------------------------------------------------
   // bus wake qualification
   // ---------------------------------------------------------------
   logic pulse_seen_reg;
   logic pulse_seen_next;
   logic bus_edge;

   // a pulse starts with a bus edge seen in sleep, an idle bus never wakes
   assign bus_edge = bus_s != bus_prev_reg;

   // wake pulse counter restarts on every bus level change
   assign wake_t.clear = !asleep(state_reg) || bus_edge || !pulse_seen_reg;

   always_comb begin
      pulse_seen_next = asleep(state_reg) && (pulse_seen_reg || bus_edge);
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pulse_seen_reg <= 1'b0;
      end else begin
         pulse_seen_reg <= pulse_seen_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs, decoded from the next state so they change with it
   // ---------------------------------------------------------------
   logic reg_en_reg;
   logic reg_en_next;
   logic xcvr_en_reg;
   logic xcvr_en_next;
   logic dom_reg;
   logic dom_next;
   logic rst_n_reg;
   logic rst_n_next;

   always_comb begin
      reg_en_next  = powered(state_next);
      xcvr_en_next = bus_allowed(state_next, out_mres_s);
      dom_next     = xcvr_en_next && out_mres_s && !tx_s;
      rst_n_next   = (state_next == seq_pkg::ST_NORMAL);
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         reg_en_reg  <= 1'b0;
         xcvr_en_reg <= 1'b0;
         dom_reg     <= 1'b0;
         rst_n_reg   <= 1'b0;
      end else begin
         reg_en_reg  <= reg_en_next;
         xcvr_en_reg <= xcvr_en_next;
         dom_reg     <= dom_next;
         rst_n_reg   <= rst_n_next;
      end
   end

   assign REGULATOR_ENABLE   = reg_en_reg;
   assign TRANSCEIVER_ENABLE = xcvr_en_reg;
   assign BUS_DOMINANT       = dom_reg;
   assign RESET_OUT_N        = rst_n_reg;
endmodule

// >>> seq_monitor.sv
// assertion checker on the sequencer ports
`timescale 1ns/1ps
module seq_monitor #(
   parameter seq_pkg::count_t RESET_DELAY  = seq_pkg::CNT_ONE,
   parameter seq_pkg::count_t WAKE_PULSE   = seq_pkg::CNT_ONE,
   parameter seq_pkg::count_t RESET_FILTER = seq_pkg::CNT_ONE
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic MODE_PIN,
   input wire logic BUS_LEVEL,
   input wire logic TX_DATA,
   input wire logic SUPPLY_BELOW_ASSERT,
   input wire logic SUPPLY_ABOVE_RELEASE,
   input wire logic OUTPUT_ABOVE_MASTER_RESET,
   input wire logic OUTPUT_ABOVE_RESET,
   input wire logic OVER_TEMPERATURE,
   input wire logic BELOW_RECOVERY,
   input wire logic REGULATOR_ENABLE,
   input wire logic TRANSCEIVER_ENABLE,
   input wire logic BUS_DOMINANT,
   input wire logic RESET_OUT_N
);
   // hold-time and dip-time counters
   seq_pkg::count_t hi_reg, hi_next, lo_reg, lo_next;
   always_comb begin
      hi_next = 20'h00000;
      lo_next = 20'h00000;
      if (REGULATOR_ENABLE && OUTPUT_ABOVE_RESET && !RESET_OUT_N) hi_next = hi_reg + 20'h00001;
      if (!OUTPUT_ABOVE_RESET) lo_next = lo_reg + 20'h00001;
   end
   always_ff @(posedge CLOCK) begin
      hi_reg <= RST ? 20'h00000 : hi_next;
      lo_reg <= RST ? 20'h00000 : lo_next;
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);
   a_release_off: assert property ($fell(RST) |-> !(REGULATOR_ENABLE || RESET_OUT_N))
      else $error("outputs active right after reset");
   a_reset_normal: assert property (RESET_OUT_N |->
      REGULATOR_ENABLE && TRANSCEIVER_ENABLE)
      else $error("reset output high outside normal mode");
   a_drive_gated: assert property (BUS_DOMINANT |-> TRANSCEIVER_ENABLE)
      else $error("bus driven with transceiver off");
   a_sleep_entry: assert property ($fell(MODE_PIN) && RESET_OUT_N && $past(MODE_PIN, 4)
      && OUTPUT_ABOVE_RESET && $past(OUTPUT_ABOVE_RESET) |-> ##2 !(REGULATOR_ENABLE
      || TRANSCEIVER_ENABLE || BUS_DOMINANT || RESET_OUT_N)) else $error("sleep entry late");
   a_delay_max: assert property (hi_reg <= RESET_DELAY + 20'h00004)
      else $error("reset output held low too long");
   a_delay_min: assert property ($rose(RESET_OUT_N) |-> hi_reg >= RESET_DELAY)
      else $error("reset output released early");
   a_dip_filter: assert property ($fell(RESET_OUT_N) && REGULATOR_ENABLE |->
      lo_reg >= RESET_FILTER) else $error("reset output dropped without filter");
   a_dip_bound: assert property (lo_reg >= RESET_FILTER + 20'h00004 |-> !RESET_OUT_N)
      else $error("reset output missed a long dip");
   a_thermal_off: assert property ((OVER_TEMPERATURE && !BELOW_RECOVERY) [*2] |=>
      !(REGULATOR_ENABLE || TRANSCEIVER_ENABLE)) else $error("active in shutdown");
   a_supply_kept: assert property ((RESET_OUT_N && MODE_PIN && OUTPUT_ABOVE_RESET
      && !OVER_TEMPERATURE) [*3] |=> REGULATOR_ENABLE) else $error("regulator dropped in normal");
endmodule
bind regulator_mode_sequencer seq_monitor #(.RESET_DELAY(RESET_DELAY), .WAKE_PULSE(WAKE_PULSE),
   .RESET_FILTER(RESET_FILTER)) u_mon (.CLOCK, .RST, .MODE_PIN, .BUS_LEVEL, .TX_DATA,
   .SUPPLY_BELOW_ASSERT, .SUPPLY_ABOVE_RELEASE, .OUTPUT_ABOVE_MASTER_RESET, .OUTPUT_ABOVE_RESET,
   .OVER_TEMPERATURE, .BELOW_RECOVERY, .REGULATOR_ENABLE, .TRANSCEIVER_ENABLE, .BUS_DOMINANT,
   .RESET_OUT_N);

// >>> node_model.sv
// controller and wired bus facing the sequencer
`timescale 1ns/1ps
module node_model (
   input  wire logic mode_req,
   input  wire logic tx_req,
   input  wire logic bus_req,
   input  wire logic dominant,
   output logic      mode_pin,
   output logic      tx_data,
   output logic      bus_level
);
   // sleep after a bus wake is mode high then low
   assign mode_pin  = mode_req;
   assign tx_data   = !tx_req;
   // pull-up bus, low when any party drives dominant
   assign bus_level = bus_req & !dominant;
endmodule

// >>> tb.sv
// self-checking bench for the regulator mode sequencer
`timescale 1ns/1ps
module tb;
   localparam seq_pkg::count_t RD = 20'h00014;
   localparam seq_pkg::count_t WP = 20'h00008;
   localparam seq_pkg::count_t RF = 20'h00004;
   logic clk = 1'b0, rst = 1'b1, sup_ok = 1'b1, mres = 1'b0, res_ok = 1'b0, hot = 1'b0;
   logic mode_req = 1'b0, tx_req = 1'b0, bus_req = 1'b1;
   logic mode_pin, tx_data, bus_level, reg_en, xcvr_en, dom, rst_n;
   wire  [3:0] outs = {reg_en, xcvr_en, dom, rst_n};
   int   err_count = 0, checks = 0, seed = 16;
   always #50 clk = !clk;
   regulator_mode_sequencer #(.RESET_DELAY(RD), .WAKE_PULSE(WP), .RESET_FILTER(RF)) u_dut (
      .CLOCK(clk), .RST(rst), .MODE_PIN(mode_pin), .BUS_LEVEL(bus_level), .TX_DATA(tx_data),
      .SUPPLY_BELOW_ASSERT(!sup_ok), .SUPPLY_ABOVE_RELEASE(sup_ok),
      .OUTPUT_ABOVE_MASTER_RESET(mres), .OUTPUT_ABOVE_RESET(res_ok), .OVER_TEMPERATURE(hot),
      .BELOW_RECOVERY(!hot), .REGULATOR_ENABLE(reg_en), .TRANSCEIVER_ENABLE(xcvr_en),
      .BUS_DOMINANT(dom), .RESET_OUT_N(rst_n));
   node_model u_node (.mode_req, .tx_req, .bus_req, .dominant(dom), .mode_pin, .tx_data,
      .bus_level);
   // 0 off, 1 hold, 2 hold with bus, 3 normal, 4 normal sending dominant
   function automatic logic [3:0] expect_out(int s);
      return {s > 0, s > 1, s > 3, s > 2};
   endfunction
   task automatic finish_test();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(string what, logic [3:0] seen, logic [3:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic wait_out(string what, logic [3:0] exp, int lim);
      int k = 0;
      while (outs !== exp && k < lim) begin
         cyc(1);
         k++;
      end
      chk(what, outs, exp);
      if (outs !== exp) finish_test();
   endtask
   task automatic come_up(string what);
      mres = 1'b1;
      wait_out(what, expect_out(2), 6);
      res_ok = 1'b1;
      cyc(int'(RD) - 2);
      chk(what, outs, expect_out(2));
      wait_out(what, expect_out(3), 8);
   endtask
   task automatic to_sleep(string what);
      mode_req = 1'b1;
      cyc(4);
      mode_req = 1'b0;
      cyc(2);
      chk(what, outs, expect_out(0));
      mres = 1'b0;
      res_ok = 1'b0;
   endtask
   task automatic bus_wake(string what);
      repeat (7) begin
         bus_req = !bus_req;
         cyc(1 + int'($unsigned($random(seed)) % 5));
      end
      chk(what, outs, expect_out(0));
      wait_out(what, expect_out(1), int'(WP) + 8);
      come_up(what);
   endtask
   initial begin
      mode_req = 1'($random(seed));
      cyc(16);
      rst = 1'b0;
      cyc(4);
      chk("power-up hold", outs, expect_out(1));
      come_up("power-up");
      tx_req = 1'b1;
      mode_req = 1'b1;
      cyc(3);
      chk("dominant", outs, expect_out(4));
      to_sleep("sleep while dominant");
      tx_req = 1'b0;
      bus_wake("low wake");
      cyc(6);
      chk("no sleep before high", outs, expect_out(3));
      to_sleep("sleep after wake");
      mode_req = 1'b1;
      wait_out("local wake", expect_out(1), 6);
      come_up("local wake");
      res_ok = 1'b0;
      cyc(int'(RF) - 2);
      res_ok = 1'b1;
      cyc(6);
      chk("short dip", outs, expect_out(3));
      res_ok = 1'b0;
      wait_out("long dip", expect_out(2), int'(RF) + 6);
      come_up("dip");
      sup_ok = 1'b0;
      cyc(10);
      chk("low supply in normal", outs, expect_out(3));
      sup_ok = 1'b1;
      hot = 1'b1;
      wait_out("shutdown", expect_out(0), 4);
      mres = 1'b0;
      res_ok = 1'b0;
      repeat (4) begin
         mode_req = 1'($random(seed));
         bus_req = 1'($random(seed));
         cyc(int'(WP) + 4);
         chk("wake in shutdown", outs, expect_out(0));
      end
      mode_req = 1'b1;
      bus_req = 1'b0;
      hot = 1'b0;
      wait_out("recover to normal", expect_out(1), 6);
      come_up("recover to normal");
      to_sleep("sleep before heat");
      hot = 1'b1;
      cyc(6);
      hot = 1'b0;
      cyc(20);
      chk("recover to sleep", outs, expect_out(0));
      bus_wake("high wake");
      to_sleep("sleep before brownout");
      sup_ok = 1'b0;
      mode_req = 1'($random(seed));
      cyc(8);
      chk("brownout in sleep", outs, expect_out(0));
      sup_ok = 1'b1;
      wait_out("brownout release", expect_out(1), 6);
      come_up("brownout release");
      rst = 1'b1;
      cyc(2);
      chk("second reset", outs, expect_out(0));
      rst = 1'b0;
      cyc(4);
      chk("hold after reset", outs, expect_out(2));
      finish_test();
   end
endmodule
